// file: hw/amo_offset_trim.sv
`default_nettype none

// One offset trim register: 16 bits stored, low 12 bits form the trim.
module amo_offset_trim (
    input  wire logic        ref_clk_i,
    input  wire logic        srst_i,
    input  wire logic        fuse_load_i,
    input  wire logic [11:0] fuse_val_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] wdata_i,
    output logic      [15:0] trim_o
);

    // Stored word, reserved bits kept so that they read back as written.
    logic [15:0] trim_reg;

    // Software write wins over a fuse load in the same cycle, so that a
    // value the user has just chosen is never overwritten silently.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            trim_reg <= amo_pkg::TRIM_RST;
        end
        else if (wr_i)
        begin
            trim_reg <= wdata_i;
        end
        else if (fuse_load_i)
        begin
            // Fuse default fills the trim field; reserved bits go to zero.
            trim_reg <= {4'h0, fuse_val_i};
        end
    end

    assign trim_o = trim_reg;

endmodule

`default_nettype wire

// file: hw/amo_regs.sv
// Function
// - Mask bit 5 keeps lane FIFO fault out.
// - Mask bit 4 keeps PLL fault out.
// - Mask bit 3 keeps link fault out.
// - Mask bit 2 keeps realign fault out.
// - Mask bit 0 keeps divider mismatch out.
// - Lane FIFO error sets its lane bit.
// - Writing one clears a lane bit.
// - Summary FIFO bit write clears all lanes.
// - Lane fault register resets to all ones.
// - Trim holds 12-bit unsigned value, applied.
// - Spare cores still calibrated in foreground.
// - Core 2 input A trim only on input A.
// - Trim defaults load from fuse memory.
// - Every alarm bit set after reset.
//
// The implementer's own choice: the strobed register port.
`default_nettype none

module amo_regs (
    input  wire logic                   ref_clk_i,
    input  wire logic                   srst_i,
    input  wire logic [11:0]            addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [15:0]            rdata_o,
    input  wire amo_pkg::amo_fault_src_t fault_i,
    input  wire logic                   fuse_load_i,
    input  wire amo_pkg::amo_fuse_trim_t fuse_i,
    input  wire logic                   core2_on_input_a_i,
    input  wire logic                   offset_cal_en_i,
    input  wire logic                   fg_offset_step_i,
    output logic      [11:0]            core0_trim_o,
    output logic      [11:0]            core1_trim_o,
    output logic      [11:0]            core2a_trim_o,
    output logic                        spare_offset_cal_o,
    output logic                        summary_alarm_o
);

    // Sticky flag update where a new event always beats the clear.
    function automatic logic [7:0] sticky_next(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] clr
    );
        sticky_next = (cur & ~clr) | set;
    endfunction

    // Register state.
    logic [7:0]  mask_reg;       // Alarm source mask.
    logic [7:0]  lane_reg;       // Per-lane FIFO fault flags.
    logic [7:0]  alarm_reg;      // Sticky source alarms, FIFO bit unused.
    logic [15:0] rdata_reg;      // Read data, valid one cycle after strobe.
    logic [15:0] trim0_w;        // Stored trim words from the trim cells.
    logic [15:0] trim1_w;
    logic [15:0] trim2a_w;
    logic [11:0] core2a_reg;     // Gated trim for core 2.
    logic        summary_reg;    // Registered summary alarm.
    logic        spare_cal_reg;  // Spare core calibration request.

    // Decoded writes.
    logic        wr_mask;
    logic        wr_lane;
    logic        wr_alarm;
    logic [7:0]  lane_set;       // Lane events this cycle.
    logic [7:0]  lane_clr;       // Lane bits cleared this cycle.
    logic [7:0]  alarm_set;      // Source events this cycle.
    logic [7:0]  alarm_clr;      // Source bits cleared this cycle.
    logic [7:0]  alarm_vec;      // Full alarm view, FIFO bit from lanes.
    logic [7:0]  unmasked_vec;   // Alarms that pass the mask.

    assign wr_mask  = wr_i && (addr_i == amo_pkg::MASK_OFS);
    assign wr_lane  = wr_i && (addr_i == amo_pkg::LANE_OFS);
    assign wr_alarm = wr_i && (addr_i == amo_pkg::ALARM_OFS);

    // Event vectors laid out on the shared bit positions.
    always_comb
    begin
        alarm_set = 8'h00;
        alarm_set[amo_pkg::DIV_BIT]     = fault_i.divider_mismatch_fault;
        alarm_set[amo_pkg::REALIGN_BIT] = fault_i.realign_fault;
        alarm_set[amo_pkg::LINK_BIT]    = fault_i.link_fault;
        alarm_set[amo_pkg::PLL_BIT]     = fault_i.pll_lock_fault;
    end

    // Source bits clear on a written one; the FIFO bit is a view only.
    assign alarm_clr = wr_alarm ? wdata_i[7:0] : 8'h00;

    assign lane_set = fault_i.lane_fifo_fault;

    always_comb
    begin
        lane_clr = 8'h00;
        if (wr_lane)
        begin
            lane_clr = wdata_i[7:0];
        end
        if (wr_alarm && wdata_i[amo_pkg::FIFO_BIT])
        begin
            lane_clr = 8'hff;
        end
    end

    // The FIFO alarm is the OR of the lanes, so it cannot disagree with
    // the lane register that software reads to find the culprit.
    always_comb
    begin
        alarm_vec = alarm_reg & amo_pkg::ALARM_USED;
        alarm_vec[amo_pkg::FIFO_BIT] = |lane_reg;
    end

    assign unmasked_vec = alarm_vec & ~mask_reg;

    // Mask register; reserved bits are stored as written, relying on
    // software to write their reset values back.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            mask_reg <= amo_pkg::MASK_RST;
        end
        else if (wr_mask)
        begin
            mask_reg <= wdata_i[7:0];
        end
    end

    // Per-lane FIFO fault flags.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            lane_reg <= amo_pkg::LANE_RST;
        end
        else
        begin
            lane_reg <= sticky_next(lane_reg, lane_set, lane_clr);
        end
    end

    // Sticky source alarms.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            alarm_reg <= amo_pkg::ALARM_RST;
        end
        else
        begin
            alarm_reg <= sticky_next(alarm_reg, alarm_set, alarm_clr)
                         & amo_pkg::ALARM_USED;
        end
    end

    // Summary alarm, registered so that the output is glitch free.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            summary_reg <= 1'b0;
        end
        else
        begin
            summary_reg <= |unmasked_vec;
        end
    end

    // Trim cells for core 0, core 1 and core 2 input A.
    // defaults come from fuses
    amo_offset_trim u_trim0 (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .fuse_load_i (fuse_load_i),
        .fuse_val_i  (fuse_i.core0),
        .wr_i        (wr_i && (addr_i == amo_pkg::CORE0_OFS)),
        .wdata_i     (wdata_i),
        .trim_o      (trim0_w)
    );

    amo_offset_trim u_trim1 (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .fuse_load_i (fuse_load_i),
        .fuse_val_i  (fuse_i.core1),
        .wr_i        (wr_i && (addr_i == amo_pkg::CORE1_OFS)),
        .wdata_i     (wdata_i),
        .trim_o      (trim1_w)
    );

    amo_offset_trim u_trim2a (
        .ref_clk_i   (ref_clk_i),
        .srst_i      (srst_i),
        .fuse_load_i (fuse_load_i),
        .fuse_val_i  (fuse_i.core2a),
        .wr_i        (wr_i && (addr_i == amo_pkg::CORE2A_OFS)),
        .wdata_i     (wdata_i),
        .trim_o      (trim2a_w)
    );

    // Core 2 takes the input A trim only while it samples input A; the
    // input B trim lives elsewhere and is applied by its own logic.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            core2a_reg <= 12'h000;
        end
        else
        begin
            core2a_reg <= core2_on_input_a_i ? trim2a_w[11:0] : 12'h000;
        end
    end

    // Spare cores are trimmed during the foreground offset step whenever
    // offset_cal_en_i is high, whatever the background settings are.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            spare_cal_reg <= 1'b0;
        end
        else
        begin
            spare_cal_reg <= offset_cal_en_i && fg_offset_step_i;
        end
    end

    // Read port: data stands only in the cycle after the strobe, and an
    // unmapped address reads as zero.
    always_ff @(posedge ref_clk_i)
    begin
        if (srst_i || !rd_i)
        begin
            rdata_reg <= 16'h0000;
        end
        else
        begin
            case (addr_i)
                amo_pkg::MASK_OFS:   rdata_reg <= {8'h00, mask_reg};
                amo_pkg::LANE_OFS:   rdata_reg <= {8'h00, lane_reg};
                amo_pkg::ALARM_OFS:  rdata_reg <= {8'h00, alarm_vec};
                amo_pkg::CORE0_OFS:  rdata_reg <= trim0_w;
                amo_pkg::CORE1_OFS:  rdata_reg <= trim1_w;
                amo_pkg::CORE2A_OFS: rdata_reg <= trim2a_w;
                default:             rdata_reg <= 16'h0000;
            endcase
        end
    end

    assign core0_trim_o       = trim0_w[11:0];
    assign core1_trim_o       = trim1_w[11:0];
    assign core2a_trim_o      = core2a_reg;
    assign rdata_o            = rdata_reg;
    assign summary_alarm_o    = summary_reg;
    assign spare_offset_cal_o = spare_cal_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);

    fifo_mask_a: assert property (
        mask_reg[amo_pkg::FIFO_BIT]
        && ((alarm_vec & ~mask_reg & ~(8'h01 << amo_pkg::FIFO_BIT)) == 8'h00)
        |=> !summary_alarm_o)
        else $error("Masked FIFO alarm reached summary.");

    pll_mask_a: assert property (
        !mask_reg[amo_pkg::PLL_BIT] && alarm_reg[amo_pkg::PLL_BIT]
        |=> summary_alarm_o)
        else $error("Unmasked PLL alarm missing from summary.");

    link_mask_a: assert property (
        mask_reg[amo_pkg::LINK_BIT] && alarm_reg[amo_pkg::LINK_BIT]
        && ((alarm_vec & ~mask_reg & ~(8'h01 << amo_pkg::LINK_BIT)) == 8'h00)
        |=> !summary_alarm_o)
        else $error("Masked link alarm reached summary.");

    realign_mask_a: assert property (
        !mask_reg[amo_pkg::REALIGN_BIT] && alarm_reg[amo_pkg::REALIGN_BIT]
        |=> summary_alarm_o)
        else $error("Unmasked realign alarm missing from summary.");

    divider_mask_a: assert property (
        !mask_reg[amo_pkg::DIV_BIT] && alarm_reg[amo_pkg::DIV_BIT]
        |=> summary_alarm_o)
        else $error("Unmasked divider alarm missing from summary.");

    lane_set_a: assert property (
        (lane_set != 8'h00) |=> ((lane_reg & $past(lane_set))
                                 == $past(lane_set)))
        else $error("Lane FIFO error did not set its flag.");

    lane_clear_a: assert property (
        wr_lane && !wr_alarm && (lane_set == 8'h00)
        |=> ((lane_reg & $past(wdata_i[7:0])) == 8'h00))
        else $error("Lane flag survived a write of one.");

    lane_all_clear_a: assert property (
        wr_alarm && wdata_i[amo_pkg::FIFO_BIT] && (lane_set == 8'h00)
        |=> (lane_reg == 8'h00))
        else $error("Summary FIFO clear left lane flags.");

    lane_reset_a: assert property (
        $past(srst_i) |-> (lane_reg == amo_pkg::LANE_RST))
        else $error("Lane flags not all set after reset.");

    trim_write_a: assert property (
        wr_i && (addr_i == amo_pkg::CORE0_OFS)
        |=> (core0_trim_o == $past(wdata_i[11:0])))
        else $error("Core 0 trim not applied after write.");

    core2_gate_a: assert property (
        !core2_on_input_a_i |=> (core2a_trim_o == 12'h000))
        else $error("Input A trim applied off input A.");

    alarm_reset_a: assert property (
        $past(srst_i) |-> (alarm_reg == amo_pkg::ALARM_RST)
                          && (mask_reg == amo_pkg::MASK_RST))
        else $error("Alarms not all set after reset.");

    summary_or_a: assert property (
        ##1 summary_alarm_o == $past(|unmasked_vec))
        else $error("Summary alarm differs from unmasked OR.");

    spare_cal_a: assert property (
        offset_cal_en_i && fg_offset_step_i |=> spare_offset_cal_o)
        else $error("Spare cores skipped in foreground step.");

endmodule

`default_nettype wire

// file: pkg/amo_pkg.sv
`default_nettype none

// Shared constants and carriers for the alarm mask and offset trim bank.
package amo_pkg;

    // Register port widths.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned TRIM_W = 12;
    localparam int unsigned LANES  = 8;

    // Register addresses on the register port.
    localparam logic [11:0] MASK_OFS   = 12'h02c2;
    localparam logic [11:0] LANE_OFS   = 12'h02c4;
    localparam logic [11:0] ALARM_OFS  = 12'h02d0;
    localparam logic [11:0] CORE0_OFS  = 12'h0330;
    localparam logic [11:0] CORE1_OFS  = 12'h0332;
    localparam logic [11:0] CORE2A_OFS = 12'h0334;

    // Alarm and mask bit positions, shared by both registers.
    localparam int unsigned DIV_BIT     = 0;
    localparam int unsigned REALIGN_BIT = 2;
    localparam int unsigned LINK_BIT    = 3;
    localparam int unsigned PLL_BIT     = 4;
    localparam int unsigned FIFO_BIT    = 5;

    // Values after reset.
    localparam logic [7:0]  MASK_RST  = 8'h3f;
    localparam logic [7:0]  LANE_RST  = 8'hff;
    localparam logic [7:0]  ALARM_RST = 8'h3d;
    localparam logic [15:0] TRIM_RST  = 16'h0000;

    // Bits of the alarm register that really hold a source.
    localparam logic [7:0]  ALARM_USED = 8'h3d;

    // Default trim values delivered by the fuse memory.
    typedef struct packed {
        logic [11:0] core0;
        logic [11:0] core1;
        logic [11:0] core2a;
    } amo_fuse_trim_t;

    // Fault sources arriving from the rest of the device.
    typedef struct packed {
        logic [7:0] lane_fifo_fault;
        logic       pll_lock_fault;
        logic       link_fault;
        logic       realign_fault;
        logic       divider_mismatch_fault;
    } amo_fault_src_t;

endpackage

`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none

// Self-checking bench for the alarm mask and offset trim register bank.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    clk;          // Register clock, 25 MHz.
    logic                    srst;         // Synchronous reset.
    logic [11:0]             addr;         // Register address.
    logic [15:0]             wdata;        // Write data.
    logic                    wr;           // Write strobe.
    logic                    rd;           // Read strobe.
    logic [15:0]             rdata;        // Read data.
    amo_pkg::amo_fault_src_t fault;        // Fault sources.
    logic                    fuse_load;    // Fuse load pulse.
    amo_pkg::amo_fuse_trim_t fuse;         // Fuse trim values.
    logic                    on_a;         // Core 2 samples input A.
    logic                    cal_en;       // Offset calibration enable.
    logic                    fg_step;      // Foreground offset step.
    logic [11:0]             trim0;        // Core 0 trim.
    logic [11:0]             trim1;        // Core 1 trim.
    logic [11:0]             trim2a;       // Core 2 input A trim.
    logic                    spare;        // Spare core calibration.
    logic                    summary;      // Summary alarm.
    logic                    rd_d;         // Read strobe one cycle late.
    logic [15:0]             exp_q[$];     // Expected read data, in order.
    logic [15:0]             lfsr;         // Random state.
    logic [15:0]             v[3];         // Trim values in flight.
    int                      bad_count;    // Mismatches.
    int                      samples_checked; // Comparisons made.

    amo_regs uut (
        .ref_clk_i          (clk),
        .srst_i             (srst),
        .addr_i             (addr),
        .wdata_i            (wdata),
        .wr_i               (wr),
        .rd_i               (rd),
        .rdata_o            (rdata),
        .fault_i            (fault),
        .fuse_load_i        (fuse_load),
        .fuse_i             (fuse),
        .core2_on_input_a_i (on_a),
        .offset_cal_en_i    (cal_en),
        .fg_offset_step_i   (fg_step),
        .core0_trim_o       (trim0),
        .core1_trim_o       (trim1),
        .core2a_trim_o      (trim2a),
        .spare_offset_cal_o (spare),
        .summary_alarm_o    (summary)
    );

    // Free-running clock; the half period is 20 ns.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        if (exp_q.size() != 0)
        begin
            bad_count++;
        end
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Sixteen-bit shift register, so every run sees the same values.
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // One write cycle; the strobe drops at the edge that takes it.
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    // One read cycle; the expected word waits for the monitor.
    task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
    endtask

    // Lets n edges pass, then looks at settled outputs.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Raises one fault source for exactly one cycle.
    task automatic pulse_src(input int b, input logic [7:0] lanes);
        amo_pkg::amo_fault_src_t f;
        f = '0;
        case (b)
            amo_pkg::DIV_BIT:     f.divider_mismatch_fault = 1'b1;
            amo_pkg::REALIGN_BIT: f.realign_fault = 1'b1;
            amo_pkg::LINK_BIT:    f.link_fault = 1'b1;
            amo_pkg::PLL_BIT:     f.pll_lock_fault = 1'b1;
            default:              f.lane_fifo_fault = lanes;
        endcase
        @(posedge clk);
        fault <= f;
        @(posedge clk);
        fault <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("unexpected read", rdata, 16'h0000);
            else
                chk("rdata", rdata, exp_q.pop_front());
        end
    end

    // A hang ends the run as a failure.
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        bad_count = 0;
        samples_checked = 0;
        lfsr = 16'h4098;
        {srst, addr, wdata, wr, rd, fault} = '0;
        {fuse_load, fuse, on_a, cal_en, fg_step} = '0;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;

        // Reset contents; every alarm masked, so no summary yet.
        rd_reg(amo_pkg::MASK_OFS, 16'h003f);
        rd_reg(amo_pkg::LANE_OFS, 16'h00ff);
        rd_reg(amo_pkg::ALARM_OFS, 16'h003d);
        rd_reg(amo_pkg::CORE0_OFS, 16'h0000);
        rd_reg(12'h0100, 16'h0000);
        settle(1);
        chk("summary", {15'h0, summary}, 16'h0000);
        $display("test reset done");

        // Clearing the summary fifo bit empties every lane at once.
        // alarms cleared first.
        wr_reg(amo_pkg::ALARM_OFS, 16'h003d);
        rd_reg(amo_pkg::LANE_OFS, 16'h0000);
        rd_reg(amo_pkg::ALARM_OFS, 16'h0000);
        pulse_src(amo_pkg::FIFO_BIT, 8'hff);
        rd_reg(amo_pkg::LANE_OFS, 16'h00ff);
        wr_reg(amo_pkg::LANE_OFS, 16'h000f);
        rd_reg(amo_pkg::LANE_OFS, 16'h00f0);
        wr_reg(amo_pkg::ALARM_OFS, 16'h0020);
        rd_reg(amo_pkg::LANE_OFS, 16'h0000);
        // A lane still in fault trips again despite the clear.
        @(posedge clk);
        fault.lane_fifo_fault <= 8'h04;
        wr_reg(amo_pkg::LANE_OFS, 16'h0004);
        rd_reg(amo_pkg::LANE_OFS, 16'h0004);
        fault <= '0;
        wr_reg(amo_pkg::LANE_OFS, 16'h0004);
        rd_reg(amo_pkg::LANE_OFS, 16'h0000);
        $display("test lanes done");

        // Each source reaches the summary only while unmasked.
        for (int b = 0; b < 6; b++)
        begin
            if (b == 1)
                continue;
            lfsr = lfsr_next(lfsr);
            wr_reg(amo_pkg::MASK_OFS, {8'h00, 8'h3f ^ (8'h01 << b)});
            pulse_src(b, 8'h01 << lfsr[2:0]);
            settle(2);
            chk("summary on", {15'h0, summary}, 16'h0001);
            // Reserved mask bits are written back as they reset.
            // reserved bits kept.
            wr_reg(amo_pkg::MASK_OFS, 16'h003f);
            settle(2);
            chk("summary masked", {15'h0, summary}, 16'h0000);
            rd_reg(amo_pkg::ALARM_OFS, 16'h0001 << b);
            wr_reg(amo_pkg::ALARM_OFS, 16'h0001 << b);
            rd_reg(amo_pkg::ALARM_OFS, 16'h0000);
        end
        $display("test masks done");

        // Trim words round trip; only the low twelve bits drive the cores.
        // no calibration, no wait.
        for (int k = 0; k < 3; k++)
        begin
            lfsr = lfsr_next(lfsr);
            v[k] = {4'h0, lfsr[11:0]};
            wr_reg(amo_pkg::CORE0_OFS + 12'(2 * k), v[k]);
            rd_reg(amo_pkg::CORE0_OFS + 12'(2 * k), v[k]);
        end
        settle(2);
        chk("trim0", {4'h0, trim0}, v[0]);
        chk("trim1", {4'h0, trim1}, v[1]);
        chk("trim2a off", {4'h0, trim2a}, 16'h0000);
        @(posedge clk);
        on_a <= 1'b1;
        settle(2);
        chk("trim2a on", {4'h0, trim2a}, v[2]);
        $display("test trims done");

        // Fuse defaults replace the trims.
        lfsr = lfsr_next(lfsr);
        @(posedge clk);
        fuse <= {lfsr[11:0], ~lfsr[11:0], lfsr[15:4]};
        fuse_load <= 1'b1;
        @(posedge clk);
        fuse_load <= 1'b0;
        settle(1);
        chk("fuse0", {4'h0, trim0}, {4'h0, lfsr[11:0]});
        chk("fuse1", {4'h0, trim1}, {4'h0, ~lfsr[11:0]});
        chk("fuse2a", {4'h0, trim2a}, {4'h0, lfsr[15:4]});
        rd_reg(amo_pkg::CORE2A_OFS, {4'h0, lfsr[15:4]});
        $display("test fuse done");

        // Spare cores calibrate only in the foreground offset step.
        // trims untouched here.
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {cal_en, fg_step} <= 2'(i);
            settle(2);
            chk("spare", {15'h0, spare}, {15'h0, i == 3});
        end
        $display("test spare done");

        // A soft reset in mid-run must bring every flag back to one.
        // reserved bits kept.
        wr_reg(amo_pkg::MASK_OFS, 16'h0002);
        rd_reg(amo_pkg::MASK_OFS, 16'h0002);
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd_reg(amo_pkg::MASK_OFS, 16'h003f);
        rd_reg(amo_pkg::LANE_OFS, 16'h00ff);
        rd_reg(amo_pkg::ALARM_OFS, 16'h003d);
        $display("test soft reset done");
        settle(2);
        end_of_test();
    end
endmodule

`default_nettype wire
